// *** hdl/shs_defines.vh ***
`ifndef SHS_DEFINES_VH
`define SHS_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SHS_REG_CTRL        8'h00
`define SHS_REG_CONFIG      8'h04
`define SHS_REG_VELOCITY    8'h08
`define SHS_REG_RAMPS       8'h0C
`define SHS_REG_OFFSET      8'h10
`define SHS_REG_GEARING     8'h14
`define SHS_REG_CURRENT     8'h18
`define SHS_REG_STATUS      8'h1C
`define SHS_REG_REFPOS      8'h20
`define SHS_REG_ID          8'h24
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SHS_CTRL_START      0
`define SHS_CTRL_STOP       1
`define SHS_CFG_TYPE_LSB    0
`define SHS_CFG_DIR_LSB     4
`define SHS_CFG_ILIM_EN     8
`define SHS_CFG_REFPOL      9
`define SHS_RAMP_DEC_LSB    16
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define SHS_RAMP_DEFAULT_MS 15'h000A
`define SHS_RAMP_MAX_MS     15'h7FFF
`define SHS_OFFSET_DEFAULT  32'h00000000
`define SHS_DIR_NEG         2'h0
`define SHS_DIR_POS         2'h1
`define SHS_DIR_SHORT       2'h2
// Arbitrary identification value
`define SHS_ID_VALUE        32'h5A5A0001
// ----------------------------------------
// Timing
// ----------------------------------------
`define SHS_CLK_MHZ         125
`define SHS_MS_CYCLES       (`SHS_CLK_MHZ * 1000)
`endif

// *** hdl/shs_sync.v ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------
module shs_sync #(
	parameter W = 4
) (
	input  wire         aclk,
	input  wire         aresetn,
	input  wire         ce,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
		end else if (ce) begin
			s1_q <= d;
			s2_q <= s1_q;
		end
	end
	assign q = s2_q;
endmodule
`default_nettype wire

// *** hdl/shs_scale.v ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Absolute position scaling: pos*num/den + offset
// ----------------------------------------
// Sequential restoring divider; one quotient bit per cycle keeps area small.
module shs_scale (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        ce,
	input  wire        start,
	input  wire [31:0] position,
	input  wire [15:0] numerator,
	input  wire [15:0] denominator,
	input  wire [31:0] offset,
	output reg         done,
	output reg  [31:0] result
);
	reg [47:0] dividend_q;
	reg [47:0] rem_q;
	reg [47:0] quot_q;
	reg [5:0]  cnt_q;
	reg        busy_q;
	reg        neg_q;
	wire [47:0] rem_sh = {rem_q[46:0], dividend_q[47]};
	wire [47:0] den_ext = {32'h00000000, denominator};
	wire [31:0] mag = position[31] ? (32'h00000000 - position) : position;
	wire [31:0] q_s = neg_q ? (32'h00000000 - quot_q[31:0]) : quot_q[31:0];
	always @(posedge aclk) begin
		if (!aresetn) begin
			dividend_q <= 48'h000000000000;
			rem_q      <= 48'h000000000000;
			quot_q     <= 48'h000000000000;
			cnt_q      <= 6'h00;
			busy_q     <= 1'b0;
			neg_q      <= 1'b0;
			done       <= 1'b0;
			result     <= 32'h00000000;
		end else if (ce) begin
			done <= 1'b0;
			if (start && !busy_q) begin
				dividend_q <= mag * numerator;
				rem_q      <= 48'h000000000000;
				quot_q     <= 48'h000000000000;
				cnt_q      <= 6'h30;
				neg_q      <= position[31];
				busy_q     <= 1'b1;
			end else if (busy_q) begin
				dividend_q <= {dividend_q[46:0], 1'b0};
				if (rem_sh >= den_ext && denominator != 16'h0000) begin
					rem_q  <= rem_sh - den_ext;
					quot_q <= {quot_q[46:0], 1'b1};
				end else begin
					rem_q  <= rem_sh;
					quot_q <= {quot_q[46:0], 1'b0};
				end
				cnt_q <= cnt_q - 6'h01;
				if (cnt_q == 6'h01)
					busy_q <= 1'b0;
			end
			if (!start && !busy_q && cnt_q == 6'h00 && quot_q != 48'h0 && !done) begin
				result <= result;
			end
			if (busy_q && cnt_q == 6'h01) begin
				done <= 1'b1;
			end
			if (done) begin
				result <= q_s + offset;
			end
		end
	end
endmodule
`default_nettype wire

// *** hdl/shs_homing.v ***
`include "shs_defines.vh"
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Type 0: reference at setpoint, no motion
// - Type 1: reference switch, then zero mark
// - Type 2: limit switch, then zero mark
// - Type 3: reference at reference switch edge
// - Type 4: reference at limit switch edge
// - Type 5: move to next zero mark
// - Type 6: reference at actual position
// - Type 7: mechanical stop, then zero mark
// - Type 7 limits current to the current register if enabled, else STOP_CURRENT
// - Type 8: scaled absolute position is target
// - Zero mark hold is within one count
// - Direction code: 0 neg, 1 pos, 2 shortest
// - Shortest direction only for type five
// - Velocity magnitude, sign from direction
// - Accel ramp 1..32767 ms, default 10
// - Decel ramp; emergency ramp at limit in types 2 and 4
// - Reference point value equals offset; type 8 adds offset to scaled position
// - Offset change waits for next homing
// - Start held; complete and loop enabled in the same cycle
module shs_homing #(
	parameter POS_PER_TURN  = 32'h00100000,
	parameter STOP_CURRENT  = 16'h0100,
	parameter STOP_CYCLES   = 32'd12500
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        ce,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        negative_limit_switch,
	input  wire        positive_limit_switch,
	input  wire        reference_switch,
	input  wire        feedback_zero_mark,
	input  wire [31:0] actual_position,
	input  wire [31:0] setpoint_position,
	input  wire [31:0] absolute_position,
	input  wire [15:0] motor_current,
	output reg  [31:0] velocity_command,
	output reg  [14:0] accel_ramp_ms,
	output reg  [14:0] decel_ramp_ms,
	output reg         emergency_ramp,
	output reg  [15:0] current_limit,
	output reg         current_limit_en,
	output reg  [31:0] reference_position,
	output reg         reference_load,
	output reg         homing_complete,
	output reg         position_loop_enable
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_IDLE   = 3'h0;
	localparam ST_SEEK   = 3'h1;
	localparam ST_MARK   = 3'h2;
	localparam ST_SCALE  = 3'h3;
	localparam ST_TARGET = 3'h4;
	localparam ST_SET    = 3'h5;
	localparam ST_DONE   = 3'h6;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg        start_q;
	reg [3:0]  type_q;
	reg [1:0]  dir_q;
	reg        ilim_en_q;
	reg        refpol_q;
	reg [31:0] vel_q;
	reg [14:0] acc_q;
	reg [14:0] dec_q;
	reg [31:0] offset_q;
	reg [15:0] num_q;
	reg [15:0] den_q;
	reg [15:0] ilim_q;
	reg [2:0]  st_q;
	reg        dir_pos_q;
	reg [31:0] ref_val_q;
	reg [31:0] off_latched_q;
	reg [31:0] stall_q;
	reg [31:0] target_q;
	reg        scale_go_q;
	reg [3:0]  pin_d1_q;
	reg        aw_hold_q;
	reg        w_hold_q;
	reg [31:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0]  wstrb_q;

	wire [3:0]  pins;
	wire        nlim = pins[0];
	wire        plim = pins[1];
	wire        refsw = pins[2] ^ refpol_q;
	wire        zmark = pins[3];
	wire        zmark_rise = pins[3] & ~pin_d1_q[3];
	wire        ref_edge = (pins[2] ^ pin_d1_q[2]);
	wire        scale_done;
	wire [31:0] scale_res;
	wire [31:0] vel_mag = vel_q[31] ? (32'h00000000 - vel_q) : vel_q;
	wire [31:0] frac = actual_position % POS_PER_TURN;

	shs_sync #(
		.W (4)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.d       ({feedback_zero_mark, reference_switch, positive_limit_switch, negative_limit_switch}),
		.q       (pins)
	);

	shs_scale u_scale (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.ce          (ce),
		.start       (scale_go_q),
		.position    (absolute_position),
		.numerator   (num_q),
		.denominator (den_q),
		.offset      (off_latched_q),
		.done        (scale_done),
		.result      (scale_res)
	);

	function [14:0] clamp_ramp;
		input [31:0] w;
		begin
			clamp_ramp = (w[14:0] == 15'h0000) ? 15'h0001 : w[14:0];
		end
	endfunction

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	wire       wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
	wire [7:0] wa = awaddr_q[7:0];
	wire       wr_map = (awaddr_q[31:8] == 24'h000000) && (wa <= `SHS_REG_ID) && (wa[1:0] == 2'h0);
	reg  [31:0] rd_mux;
	reg         rd_ok;
	always @* begin
		rd_ok = (s_axi_araddr[31:8] == 24'h000000) && (s_axi_araddr[1:0] == 2'h0);
		case (s_axi_araddr[7:0])
		`SHS_REG_CTRL:     rd_mux = {31'h00000000, start_q};
		`SHS_REG_CONFIG:   rd_mux = {22'h000000, refpol_q, ilim_en_q, 2'h0, dir_q, type_q};
		`SHS_REG_VELOCITY: rd_mux = vel_q;
		`SHS_REG_RAMPS:    rd_mux = {1'b0, dec_q, 1'b0, acc_q};
		`SHS_REG_OFFSET:   rd_mux = offset_q;
		`SHS_REG_GEARING:  rd_mux = {den_q, num_q};
		`SHS_REG_CURRENT:  rd_mux = {16'h0000, ilim_q};
		`SHS_REG_STATUS:   rd_mux = {23'h000000, pins, st_q, homing_complete, position_loop_enable};
		`SHS_REG_REFPOS:   rd_mux = reference_position;
		`SHS_REG_ID:       rd_mux = `SHS_ID_VALUE;
		default: begin
			rd_mux = 32'h00000000;
			rd_ok  = 1'b0;
		end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= 2'h0;
			s_axi_rdata   <= 32'h00000000;
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			awaddr_q      <= 32'h00000000;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			start_q       <= 1'b0;
			type_q        <= 4'h0;
			dir_q         <= `SHS_DIR_NEG;
			ilim_en_q     <= 1'b0;
			refpol_q      <= 1'b0;
			vel_q         <= 32'h00000000;
			acc_q         <= `SHS_RAMP_DEFAULT_MS;
			dec_q         <= `SHS_RAMP_DEFAULT_MS;
			offset_q      <= `SHS_OFFSET_DEFAULT;
			num_q         <= 16'h0001;
			den_q         <= 16'h0001;
			ilim_q        <= 16'hFFFF;
		end else if (ce) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_arready <= 1'b0;
			if (s_axi_awvalid && !aw_hold_q && !s_axi_awready) begin
				s_axi_awready <= 1'b1;
				aw_hold_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_hold_q && !s_axi_wready) begin
				s_axi_wready <= 1'b1;
				w_hold_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? 2'h0 : 2'h2;
				// Whole-word writes only; partial strobes would split ramps and gearing
				if (wr_map && wstrb_q == 4'hF) begin
					case (wa)
					`SHS_REG_CTRL:     start_q <= wdata_q[`SHS_CTRL_START] & ~wdata_q[`SHS_CTRL_STOP];
					`SHS_REG_CONFIG: begin
						type_q    <= wdata_q[`SHS_CFG_TYPE_LSB +: 4];
						dir_q     <= wdata_q[`SHS_CFG_DIR_LSB +: 2];
						ilim_en_q <= wdata_q[`SHS_CFG_ILIM_EN];
						refpol_q  <= wdata_q[`SHS_CFG_REFPOL];
					end
					`SHS_REG_VELOCITY: vel_q <= wdata_q;
					`SHS_REG_RAMPS: begin
						acc_q <= clamp_ramp(wdata_q);
						dec_q <= clamp_ramp(wdata_q >> `SHS_RAMP_DEC_LSB);
					end
					`SHS_REG_OFFSET:   offset_q <= wdata_q;
					`SHS_REG_GEARING: begin
						num_q <= wdata_q[15:0];
						den_q <= wdata_q[31:16];
					end
					`SHS_REG_CURRENT:  ilim_q <= wdata_q[15:0];
					default: ;
					endcase
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_mux;
				s_axi_rresp   <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Homing sequencer
	// ----------------------------------------
	// Limit and reference edges are taken at the synchronised level, so the
	// captured position lags the true transition by a few position-loop cycles.
	always @(posedge aclk) begin
		if (!aresetn) begin
			st_q                 <= ST_IDLE;
			dir_pos_q            <= 1'b0;
			ref_val_q            <= 32'h00000000;
			off_latched_q        <= 32'h00000000;
			stall_q              <= 32'h00000000;
			target_q             <= 32'h00000000;
			scale_go_q           <= 1'b0;
			pin_d1_q             <= 4'h0;
			velocity_command     <= 32'h00000000;
			accel_ramp_ms        <= `SHS_RAMP_DEFAULT_MS;
			decel_ramp_ms        <= `SHS_RAMP_DEFAULT_MS;
			emergency_ramp       <= 1'b0;
			current_limit        <= 16'hFFFF;
			current_limit_en     <= 1'b0;
			reference_position   <= 32'h00000000;
			reference_load       <= 1'b0;
			homing_complete      <= 1'b0;
			position_loop_enable <= 1'b0;
		end else if (ce) begin
			pin_d1_q       <= pins;
			reference_load <= 1'b0;
			scale_go_q     <= 1'b0;
			accel_ramp_ms  <= acc_q;
			decel_ramp_ms  <= dec_q;
			if (!start_q && st_q != ST_IDLE) begin
				// Start dropped or stop: abort, loop stays off
				st_q             <= ST_IDLE;
				velocity_command <= 32'h00000000;
				emergency_ramp   <= 1'b0;
				current_limit_en <= 1'b0;
				current_limit    <= 16'hFFFF;
			end else begin
				case (st_q)
				ST_IDLE: begin
					if (start_q && !homing_complete) begin
						homing_complete      <= 1'b0;
						position_loop_enable <= 1'b0;
						off_latched_q        <= offset_q;
						stall_q              <= 32'h00000000;
						emergency_ramp       <= 1'b0;
						// Shortest way: past half a turn the mark is nearer ahead
						if (dir_q == `SHS_DIR_SHORT && type_q == 4'h5)
							dir_pos_q <= (frac >= (POS_PER_TURN >> 1));
						else
							dir_pos_q <= (dir_q == `SHS_DIR_POS);
						case (type_q)
						4'h0: begin
							ref_val_q <= setpoint_position;
							st_q      <= ST_SET;
						end
						4'h6: begin
							ref_val_q <= actual_position;
							st_q      <= ST_SET;
						end
						4'h8: begin
							scale_go_q <= 1'b1;
							st_q       <= ST_SCALE;
						end
						4'h5:    st_q <= ST_MARK;
						default: st_q <= ST_SEEK;
						endcase
						if (type_q == 4'h7) begin
							current_limit_en <= 1'b1;
							current_limit    <= ilim_en_q ? ilim_q : STOP_CURRENT;
						end
					end else if (!start_q) begin
						homing_complete <= 1'b0;
					end
				end
				ST_SEEK: begin
					velocity_command <= dir_pos_q ? vel_mag : (32'h00000000 - vel_mag);
					case (type_q)
					4'h1, 4'h3: begin
						if (ref_edge && refsw) begin
							if (type_q == 4'h3) begin
								ref_val_q <= actual_position;
								st_q      <= ST_SET;
							end else begin
								st_q <= ST_MARK;
							end
						end else if ((dir_pos_q && plim) || (!dir_pos_q && nlim)) begin
							dir_pos_q <= ~dir_pos_q;
						end
					end
					4'h2, 4'h4: begin
						if ((dir_pos_q && plim) || (!dir_pos_q && nlim)) begin
							emergency_ramp <= 1'b1;
							dir_pos_q      <= ~dir_pos_q;
							if (type_q == 4'h4) begin
								ref_val_q <= actual_position;
								st_q      <= ST_SET;
							end else begin
								st_q <= ST_MARK;
							end
						end
					end
					default: begin
						// Mechanical stop seen as current at limit for a held time
						if (motor_current >= current_limit)
							stall_q <= stall_q + 32'h00000001;
						else
							stall_q <= 32'h00000000;
						if (stall_q >= STOP_CYCLES) begin
							dir_pos_q <= ~dir_pos_q;
							st_q      <= ST_MARK;
						end
					end
					endcase
				end
				ST_MARK: begin
					velocity_command <= dir_pos_q ? vel_mag : (32'h00000000 - vel_mag);
					// Loop holds only within one count, so a restart may go a full turn
					if (zmark_rise) begin
						ref_val_q <= actual_position;
						st_q      <= ST_SET;
					end
				end
				ST_SCALE: begin
					if (scale_done)
						st_q <= ST_TARGET;
				end
				ST_TARGET: begin
					// Completion waits for the done state, one cycle after the load
					target_q           <= scale_res;
					reference_position <= scale_res;
					reference_load     <= 1'b1;
					st_q               <= ST_DONE;
				end
				ST_SET: begin
					velocity_command   <= 32'h00000000;
					reference_position <= off_latched_q;
					reference_load     <= 1'b1;
					st_q               <= ST_DONE;
				end
				ST_DONE: begin
					current_limit_en     <= 1'b0;
					current_limit        <= 16'hFFFF;
					emergency_ramp       <= 1'b0;
					homing_complete      <= 1'b1;
					position_loop_enable <= 1'b1;
					st_q                 <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/shs_homing_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module shs_homing_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [14:0] accel_ramp_ms,
	input wire logic [14:0] decel_ramp_ms,
	input wire logic        reference_load,
	input wire logic        homing_complete,
	input wire logic        position_loop_enable
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ------------------------------
	// Bus timing
	// ------------------------------
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held too long");
	a_b_answer: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
	a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid after handshake");
	a_r_answer: assert property (s_axi_arready |-> s_axi_rvalid) else $error("read answer late");
	a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid after handshake");
	// ------------------------------
	// Homing outputs
	// ------------------------------
	a_ramp_floor: assert property (accel_ramp_ms != 15'h0000 && decel_ramp_ms != 15'h0000)
		else $error("ramp time of zero");
	a_load_pulse: assert property (reference_load |=> !reference_load) else $error("load not a pulse");
	a_load_done: assert property (reference_load |=> homing_complete && position_loop_enable)
		else $error("no completion after load");
	a_done_cause: assert property ($rose(homing_complete) |-> $past(reference_load))
		else $error("completion without load");
endmodule
bind shs_homing shs_homing_asserts u_shs_homing_asserts (.*);
`default_nettype wire

// *** tb/shs_axis_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Axis with switches, zero mark and a hard stop
// ------------------------------
// Moves one count per cycle whatever the speed, so every event is a clean edge.
module shs_axis_model (
	input wire logic         aclk,
	input wire logic         aresetn,
	input wire logic [31:0]  velocity_command,
	output logic             negative_limit_switch,
	output logic             positive_limit_switch,
	output logic             reference_switch,
	output logic             feedback_zero_mark,
	output logic [31:0]      actual_position,
	output logic [15:0]      motor_current
);
	logic signed [31:0] pos_q;
	logic               at_stop;
	always @(posedge aclk) begin
		if (!aresetn)
			pos_q <= 32'sh00000064;
		else if (velocity_command[31] && !at_stop)
			pos_q <= pos_q - 1;
		else if (!velocity_command[31] && velocity_command != 32'h00000000)
			pos_q <= pos_q + 1;
	end
	// Hard stop lies beyond the negative limit so switch homing can reverse there
	assign at_stop               = pos_q <= -32'sh00000096;
	assign actual_position       = pos_q;
	assign feedback_zero_mark    = pos_q[7:0] == 8'h00;
	assign reference_switch      = pos_q >= 32'sh0000012C;
	assign positive_limit_switch = pos_q >= 32'sh00000258;
	assign negative_limit_switch = pos_q <= -32'sh00000064;
	// Stall current only while pushing into the stop
	assign motor_current         = (at_stop && velocity_command[31]) ? 16'hFFFF : 16'h0010;
endmodule
`default_nettype wire

// *** tb/test_servo_homing_sequencer.sv ***
`include "shs_defines.vh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_servo_homing_sequencer;
	logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, setpoint_position, absolute_position;
	logic [3:0]  s_axi_wstrb;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, reference_load;
	wire         homing_complete, position_loop_enable, emergency_ramp, current_limit_en;
	wire         negative_limit_switch, positive_limit_switch, reference_switch, feedback_zero_mark;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata, velocity_command, reference_position, actual_position;
	wire [14:0]  accel_ramp_ms, decel_ramp_ms;
	wire [15:0]  current_limit, motor_current;
	int          fail_count, n_tests, n_load;
	logic [31:0] rs, off, ap, nm, dn, ref_seen;
	logic [15:0] cl;
	logic        done_load, mv, sg, em, il;
	shs_homing #(.POS_PER_TURN(32'h00000100), .STOP_CYCLES(32'h00000004)) u_shs_homing (.*);
	shs_axis_model u_shs_axis_model (.*);
	// ------------------------------
	// Helpers
	// ------------------------------
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int t;
		s_axi_awaddr <= {24'h000000, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (t = 0; t < 64; t++) begin
			@(posedge aclk);
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (t == 64) fail_count++;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		s_axi_araddr <= {24'h000000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (t = 0; t < 64; t++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (t == 64) fail_count++;
		@(posedge aclk);
	endtask
	// The pulse can land inside a bus task, so a free monitor catches it
	always @(posedge aclk) begin
		if (reference_load) begin
			n_load++;
			ref_seen = reference_position;
			done_load = homing_complete;
		end
		if (velocity_command != 32'h00000000 && !mv) begin
			mv = 1'b1;
			sg = velocity_command[31];
		end
		em |= emergency_ramp;
		il |= current_limit_en;
		if (current_limit_en) cl = current_limit;
	end
	task automatic home(input int ty, input int dr);
		logic [31:0] ex;
		logic        es;
		int          base, t;
		es = (dr == 2) ? !actual_position[7] : (dr == 0);
		ex = (ty == 8) ? (ap * nm) / dn + off : off;
		mv = 1'b0; em = 1'b0; il = 1'b0; cl = 16'h0000;
		base = n_load;
		setpoint_position <= xs();
		wr(`SHS_REG_CONFIG, ty | (dr << 4) | ((ty == 7) << 8));
		wr(`SHS_REG_CTRL, 32'h00000001);
		for (t = 0; t < 8000 && n_load == base; t++) @(posedge aclk);
		`CHK(n_load, base + 1)
		`CHK(ref_seen, ex)
		`CHK(done_load, 1'b0)
		@(posedge aclk);
		`CHK(homing_complete, 1'b1)
		`CHK(position_loop_enable, 1'b1)
		if (ty == 0 || ty == 6) `CHK(mv, 1'b0)
		else if (ty != 8) `CHK(sg, es)
		`CHK(em, ty == 2 || ty == 4)
		`CHK(il, ty == 7)
		if (ty == 7) `CHK(cl, 16'h0200)
		off = xs() & 32'h0000003F;
		wr(`SHS_REG_OFFSET, off);
		`CHK(reference_position, ex)
		wr(`SHS_REG_CTRL, 32'h00000000);
		@(posedge aclk);
		`CHK(homing_complete, 1'b0)
		for (t = 0; t < 400 && velocity_command !== 32'h00000000; t++) @(posedge aclk);
	endtask
	// ------------------------------
	// Stimulus
	// ------------------------------
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	initial begin
		#(64'd640000);
		fail_count++;
		test_done;
	end
	initial begin
		logic [7:0]  ra [5] = '{`SHS_REG_RAMPS, `SHS_REG_OFFSET, `SHS_REG_GEARING, `SHS_REG_CURRENT, 8'h40};
		logic [31:0] rv [5] = '{32'h000A000A, 32'h00000000, 32'h00010001, 32'h0000FFFF, 32'h00000000};
		int          ty [10] = '{5, 1, 3, 5, 2, 4, 7, 0, 6, 8};
		int          dr [10] = '{1, 1, 0, 2, 1, 1, 0, 1, 1, 1};
		logic [31:0] d;
		logic [1:0]  r;
		int          i;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, setpoint_position, absolute_position} = 160'h0;
		s_axi_wstrb = 4'hF;
		ce = 1'b1;
		aresetn = 1'b0;
		rs = 32'hD1E3B67A;
		fail_count = 0; n_tests = 0; n_load = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 5; i++) begin
			rd(ra[i], d, r);
			`CHK(d, rv[i])
			`CHK(r, (i == 4) ? 2'h2 : 2'h0)
		end
		s_axi_wstrb <= 4'h3;
		wr(`SHS_REG_OFFSET, 32'h00001234);
		s_axi_wstrb <= 4'hF;
		rd(`SHS_REG_OFFSET, d, r);
		`CHK(d, 32'h00000000)
		wr(`SHS_REG_RAMPS, 32'h00000000);
		`CHK({accel_ramp_ms, decel_ramp_ms}, 30'h00008001)
		wr(`SHS_REG_RAMPS, 32'h7FFF7FFF);
		`CHK({accel_ramp_ms, decel_ramp_ms}, 30'h3FFFFFFF)
		// Shortest ramps keep each run brief
		wr(`SHS_REG_RAMPS, 32'h00010001);
		wr(`SHS_REG_VELOCITY, 32'hFFF0BDC0);
		wr(`SHS_REG_CURRENT, 32'h00000200);
		dn = (xs() & 32'h000000FF) | 32'h00000001;
		nm = xs() % dn + 1;
		ap = xs() & 32'h000000FF;
		absolute_position <= ap;
		wr(`SHS_REG_GEARING, {dn[15:0], nm[15:0]});
		off = xs() & 32'h0000003F;
		wr(`SHS_REG_OFFSET, off);
		for (i = 0; i < 10; i++) home(ty[i], dr[i]);
		test_done;
	end
endmodule
`default_nettype wire
